// *** rtl/bus_port_gpio_altfunc.sv ***
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module bus_port_gpio_altfunc (
  // system
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // register port
  input  wire port_pkg::reg_req_t       req,
  output logic [port_pkg::DATA_W-1:0]   rdata,
  // peripheral side
  input  wire port_pkg::alt_drive_t     periph,
  output logic [port_pkg::PINS-1:0]     alt_in,
  // port b pins
  input  wire logic [port_pkg::PINS-1:0] b_in,
  output logic [port_pkg::PINS-1:0]     b_out,
  output logic [port_pkg::PINS-1:0]     b_oe,
  // port a pins
  input  wire logic [port_pkg::PINS-1:0] ad_in,
  output logic [port_pkg::PINS-1:0]     ad_out,
  output logic [port_pkg::PINS-1:0]     ad_oe
);
  import port_pkg::*;

  typedef struct packed {
    logic [PINS-1:0]   alt;
    logic [PINS-1:0]   dir;
    logic [PINS-1:0]   latch;
    logic [DATA_W-1:0] ext_addr;
    logic [DATA_W-1:0] ext_wdata;
    logic [DATA_W-1:0] ext_rdata;
    logic              ext_write;
    logic              ext_byte;
    bus_state_t        bus;
    logic [3:0]        cnt;
    logic [PINS-1:0]   b_out;
    logic [PINS-1:0]   b_oe;
    logic [PINS-1:0]   ad_out;
    logic [PINS-1:0]   ad_oe;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t          st_reg;
  state_t          st_next;
  logic [31:0]     lvl;
  logic [PINS-1:0] lvl_b;
  logic [PINS-1:0] lvl_a;
  logic [PINS-1:0] bus_lvl;
  logic            cmd_go;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs; synchroniser lag means port a data must settle early
  pin_sync #(
    .W (32)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   ({ad_in, b_in}),
    .level (lvl)
  );

  assign lvl_b  = lvl[15:0];
  assign lvl_a  = lvl[31:16];
  assign cmd_go = req.we && (req.addr == OFS_EXT_CMD) && (st_reg.bus == B_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = '0;

    // register writes
    if (req.we) begin
      case (req.addr)
        OFS_ALT_SEL: st_next.alt = req.wdata | BUS_PIN_MASK;
        OFS_DIR:     st_next.dir = req.wdata;
        OFS_LATCH:   st_next.latch = req.wdata;
        OFS_EXT_ADR: begin
          if (st_reg.bus == B_IDLE) begin
            st_next.ext_addr = req.wdata;
          end
        end
        OFS_EXT_DAT: begin
          if (st_reg.bus == B_IDLE) begin
            st_next.ext_wdata = req.wdata;
          end
        end
        default: ;
      endcase
    end

    // register reads
    if (req.re) begin
      case (req.addr)
        // bus control bits read back as fixed
        OFS_ALT_SEL: st_next.rdata = st_reg.alt;
        OFS_DIR:     st_next.rdata = st_reg.dir;
        OFS_LATCH:   st_next.rdata = (st_reg.latch & st_reg.dir) | (lvl_b & ~st_reg.dir);
        OFS_LEVEL:   st_next.rdata = lvl_b;
        OFS_EXT_ADR: st_next.rdata = st_reg.ext_addr;
        OFS_EXT_DAT: st_next.rdata = st_reg.ext_rdata;
        OFS_EXT_CMD: begin
          st_next.rdata[CMD_WRITE_BIT] = st_reg.ext_write;
          st_next.rdata[CMD_BYTE_BIT]  = st_reg.ext_byte;
        end
        OFS_EXT_STA: st_next.rdata[STA_BUSY_BIT] = (st_reg.bus != B_IDLE);
        default:     st_next.rdata = '0;
      endcase
    end

    // external cycle sequencer; commands while busy are dropped
    case (st_reg.bus)
      B_IDLE: begin
        if (cmd_go) begin
          st_next.ext_write = req.wdata[CMD_WRITE_BIT];
          st_next.ext_byte  = req.wdata[CMD_BYTE_BIT];
          st_next.cnt       = ALE_CYC - 4'h1;
          // every cycle opens with the latch strobe
          st_next.bus       = B_ADDR;
        end
      end
      B_ADDR: begin
        if (st_reg.cnt == 4'h0) begin
          st_next.bus = B_STROBE;
          st_next.cnt = st_reg.ext_write ? WR_CYC - 4'h1 : RD_CYC - 4'h1;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      B_STROBE: begin
        if (st_reg.cnt == 4'h0) begin
          if (!st_reg.ext_write) begin
            st_next.ext_rdata = lvl_a;
          end
          st_next.bus = B_HOLD;
          st_next.cnt = HOLD_CYC - 4'h1;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      B_HOLD: begin
        if (st_reg.cnt == 4'h0) begin
          st_next.bus = B_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      default: st_next.bus = B_IDLE;
    endcase

    // address phase then data phase on port a
    case (st_reg.bus)
      B_ADDR: begin
        st_next.ad_out = st_reg.ext_addr;
        st_next.ad_oe  = '1;
      end
      B_STROBE,
      B_HOLD: begin
        st_next.ad_out = st_reg.ext_wdata;
        st_next.ad_oe  = {PINS{st_reg.ext_write}};
      end
      default: begin
        st_next.ad_out = '0;
        st_next.ad_oe  = '0;
      end
    endcase

    // bus control levels, read and write strobes active low, latch strobe active high
    bus_lvl          = '0;
    bus_lvl[PIN_ALE] = (st_reg.bus == B_ADDR);
    bus_lvl[PIN_WR]  = !((st_reg.bus == B_STROBE) && st_reg.ext_write);
    bus_lvl[PIN_RD]  = !((st_reg.bus == B_STROBE) && !st_reg.ext_write);
    // high lane enabled for words and odd bytes
    bus_lvl[PIN_HBE] = st_reg.ext_byte && !st_reg.ext_addr[0];

    st_next.b_oe  = BUS_PIN_MASK
                  | (st_reg.alt & ~BUS_PIN_MASK & periph.oe)
                  | (~st_reg.alt & st_reg.dir);
    // bus control, latch or peripheral level onto the pin
    st_next.b_out = (BUS_PIN_MASK & bus_lvl)
                  | (st_reg.alt & ~BUS_PIN_MASK & periph.level)
                  | (~st_reg.alt & st_reg.latch);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg           <= '0;
      st_reg.alt       <= RST_ALT_SEL;
      st_reg.dir       <= RST_DIR;
      st_reg.latch     <= RST_LATCH;
      st_reg.ext_addr  <= RST_EXT;
      st_reg.ext_wdata <= RST_EXT;
      st_reg.ext_rdata <= RST_EXT;
      st_reg.bus       <= B_IDLE;
      st_reg.b_out     <= BUS_PIN_MASK & ~(16'h0001 << PIN_ALE) & ~(16'h0001 << PIN_HBE);
      st_reg.b_oe      <= BUS_PIN_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata  = st_reg.rdata;
  assign b_out  = st_reg.b_out;
  assign b_oe   = st_reg.b_oe;
  assign ad_out = st_reg.ad_out;
  assign ad_oe  = st_reg.ad_oe;
  assign alt_in = lvl_b;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_bus_bits_fixed: assert property (
    req.re && req.addr == OFS_ALT_SEL |=> (rdata & BUS_PIN_MASK) == BUS_PIN_MASK)
    else $error("bus control select bits not fixed");

  chk_input_hiz: assert property (
    1'b1 |=> (b_oe & ~$past(st_reg.alt) & ~$past(st_reg.dir)) == 16'h0000)
    else $error("input pin driven");

  chk_output_on: assert property (
    1'b1 |=> (b_oe & ~$past(st_reg.alt) & $past(st_reg.dir)) == (~$past(st_reg.alt) & $past(st_reg.dir)))
    else $error("output pin not driven");

  chk_latch_store: assert property (
    req.we && req.addr == OFS_LATCH |=> st_reg.latch == $past(req.wdata))
    else $error("latch write lost");

  chk_read_input: assert property (
    req.re && req.addr == OFS_LATCH
    |=> (rdata & ~$past(st_reg.dir)) == ($past(lvl_b) & ~$past(st_reg.dir)))
    else $error("input read not pin level");

  // latch reaches pin after two edges
  chk_latch_drive: assert property (
    req.we && req.addr == OFS_LATCH ##1 1'b1
    |=> ((b_out ^ $past(req.wdata, 2)) & $past(st_reg.dir) & ~$past(st_reg.alt)) == 16'h0000)
    else $error("latch value not on output pin");

  chk_read_output: assert property (
    req.re && req.addr == OFS_LATCH
    |=> (rdata & $past(st_reg.dir)) == ($past(st_reg.latch) & $past(st_reg.dir)))
    else $error("output read not latch");

  chk_alt_select: assert property (
    req.we && req.addr == OFS_ALT_SEL |=> st_reg.alt == ($past(req.wdata) | BUS_PIN_MASK))
    else $error("select register wrong");

  // peripheral level on pins 0 to 7
  chk_alt_level: assert property (
    1'b1 |=> ((b_out ^ $past(periph.level)) & $past(st_reg.alt) & 16'h00ff) == 16'h0000)
    else $error("peripheral level not on pin");

  chk_sync_select: assert property (
    1'b1 |=> ((b_out ^ $past(periph.level)) & $past(st_reg.alt) & SYNC_SEL_MASK) == 16'h0000)
    else $error("sync or select level not on pin");

  chk_bus_driven: assert property (
    1'b1 |=> (b_oe & BUS_PIN_MASK) == BUS_PIN_MASK)
    else $error("bus control pin undriven");

  chk_addr_phase: assert property (
    st_reg.bus == B_ADDR |=> ad_oe == 16'hffff && ad_out == $past(st_reg.ext_addr))
    else $error("address not on port a");

  chk_ale_pulse: assert property (
    cmd_go |-> ##2 b_out[PIN_ALE] [*2] ##1 !b_out[PIN_ALE])
    else $error("latch strobe wrong");

  chk_read_strobe: assert property (
    st_reg.bus == B_STROBE && !st_reg.ext_write |=> !b_out[PIN_RD] && b_out[PIN_WR])
    else $error("read strobe wrong");

  chk_write_strobe: assert property (
    st_reg.bus == B_STROBE && st_reg.ext_write |=> !b_out[PIN_WR] && b_out[PIN_RD])
    else $error("write strobe wrong");

  // write data phase on port a
  chk_data_phase: assert property (
    st_reg.bus == B_STROBE && st_reg.ext_write
    |=> ad_oe == 16'hffff && ad_out == $past(st_reg.ext_wdata))
    else $error("write data not on port a");

  chk_bus_released: assert property (
    st_reg.bus == B_IDLE |=> ad_oe == 16'h0000)
    else $error("port a driven while idle");

  chk_lane_select: assert property (
    st_reg.bus == B_ADDR
    |=> b_out[PIN_HBE] == ($past(st_reg.ext_byte) && !$past(st_reg.ext_addr[0]))
        && ad_out[0] == $past(st_reg.ext_addr[0]))
    else $error("lane select wrong");

  chk_alt_dir: assert property (
    1'b1 |=> ((b_oe ^ $past(periph.oe)) & $past(st_reg.alt) & ~BUS_PIN_MASK) == 16'h0000)
    else $error("peripheral direction not applied");

  cov_ext_read:  cover property (cmd_go && !req.wdata[CMD_WRITE_BIT] ##[1:20] st_reg.bus == B_IDLE);
  cov_ext_write: cover property (cmd_go && req.wdata[CMD_WRITE_BIT] ##[1:20] st_reg.bus == B_IDLE);
  cov_odd_byte:  cover property (st_reg.bus == B_ADDR && st_reg.ext_byte && st_reg.ext_addr[0]);
  cov_alt_pin:   cover property (|(st_reg.alt & ~BUS_PIN_MASK & periph.oe));

endmodule : bus_port_gpio_altfunc
`default_nettype wire

// *** rtl/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 32
) (
  // system
  input  wire logic         clk,
  input  wire logic         rst_b,
  // pins
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  import port_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  ////////////////////////////////////////////////////////////////////////////
  // s1 feeds only s2; a bit changes once s2 and s3 agree
  always_comb begin
    sync_next        = sync_reg;
    sync_next.s1     = pin;
    sync_next.s2     = sync_reg.s1;
    sync_next.s3     = sync_reg.s2;
    sync_next.stable = (sync_reg.s2 & sync_reg.s3)
                     | (sync_reg.stable & (sync_reg.s2 ^ sync_reg.s3));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.stable;

endmodule : pin_sync
`default_nettype wire

// *** rtl/port_pkg.sv ***
package port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PINS   = 16;
  localparam int unsigned ADDR_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_ALT_SEL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR     = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_LATCH   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_LEVEL   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_EXT_ADR = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_EXT_DAT = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_EXT_CMD = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_EXT_STA = 5'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CMD_WRITE_BIT = 0;
  localparam int unsigned CMD_BYTE_BIT  = 1;
  localparam int unsigned STA_BUSY_BIT  = 0;

  // pin positions of the alternate functions
  localparam logic [3:0] PIN_SERIAL_TX  = 4'h0;
  localparam logic [3:0] PIN_PER_STROBE = 4'h1;
  localparam logic [3:0] PIN_SERIAL_CLK = 4'h2;
  localparam logic [3:0] PIN_TIMER2_IO  = 4'h3;
  localparam logic [3:0] PIN_TIMER3_IO  = 4'h4;
  localparam logic [3:0] PIN_SHIFT_DATA = 4'h5;
  localparam logic [3:0] PIN_SHIFT_CLK  = 4'h6;
  localparam logic [3:0] PIN_HOLD_ACK   = 4'h7;
  localparam logic [3:0] PIN_SYNC_SEL_0 = 4'h8;
  localparam logic [3:0] PIN_SYNC_SEL_1 = 4'h9;
  localparam logic [3:0] PIN_ALE        = 4'ha;
  localparam logic [3:0] PIN_WR         = 4'hb;
  localparam logic [3:0] PIN_HBE        = 4'hc;
  localparam logic [3:0] PIN_SYNC_SEL_2 = 4'hd;
  localparam logic [3:0] PIN_SYNC_SEL_3 = 4'he;
  localparam logic [3:0] PIN_RD         = 4'hf;

  localparam logic [PINS-1:0] BUS_PIN_MASK  = 16'h9c00;
  localparam logic [PINS-1:0] SYNC_SEL_MASK = 16'h6300;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DATA_W-1:0] RST_ALT_SEL = 16'h9c00;
  localparam logic [DATA_W-1:0] RST_DIR     = 16'h0000;
  localparam logic [DATA_W-1:0] RST_LATCH   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_EXT     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // timing, picoseconds, least times rounded up
  localparam int unsigned CLK_PS    = 8000;
  localparam int unsigned T_ALE_PS  = 15000;
  localparam int unsigned T_RD_PS   = 47500;
  localparam int unsigned T_WR_PS   = 72500;
  localparam int unsigned T_HOLD_PS = 15000;
  localparam logic [3:0] ALE_CYC  = 4'((T_ALE_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] RD_CYC   = 4'((T_RD_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] WR_CYC   = 4'((T_WR_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_PS + CLK_PS - 1) / CLK_PS);

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {B_IDLE, B_ADDR, B_STROBE, B_HOLD} bus_state_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [PINS-1:0] level;
    logic [PINS-1:0] oe;
  } alt_drive_t;

endpackage : port_pkg

// *** sim/ext_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  // system
  input  wire logic                        clk,
  input  wire logic                        slow,
  // port b bus controls
  input  wire logic [port_pkg::PINS-1:0]   b_out,
  input  wire logic [port_pkg::PINS-1:0]   b_oe,
  // port a address/data
  input  wire logic [port_pkg::PINS-1:0]   ad_out,
  input  wire logic [port_pkg::PINS-1:0]   ad_oe,
  output logic      [port_pkg::PINS-1:0]   ad_in
);
  import port_pkg::*;

  logic [15:0] mem [16];
  logic [15:0] adr_q;
  logic [15:0] float_q = 16'h5a5a;
  logic        rd_late = 1'b0;
  logic        wr_q    = 1'b0;
  logic        hbe_q   = 1'b0;
  logic        ale;
  logic        rd_act;
  logic        wr_act;
  logic [15:0] drive;

  ////////////////////////////////////////////////////////////////////////////
  assign ale    = b_oe[PIN_ALE] & b_out[PIN_ALE];
  assign rd_act = b_oe[PIN_RD] & ~b_out[PIN_RD];
  assign wr_act = b_oe[PIN_WR] & ~b_out[PIN_WR];

  // undriven bus toggles, so stale data never looks valid
  always @(posedge clk) begin
    float_q <= ~float_q;
    wr_q    <= wr_act;
    if (ale) begin
      adr_q <= ad_out;
    end
    if (wr_act) begin
      hbe_q <= ~b_out[PIN_HBE];
    end
    if (wr_q && !wr_act) begin
      if (!adr_q[0]) begin
        mem[adr_q[4:1]][7:0] <= ad_out[7:0];
      end
      if (hbe_q) begin
        mem[adr_q[4:1]][15:8] <= ad_out[15:8];
      end
    end
  end

  // slow memory answers half a cycle into the read strobe; any later and
  // the four-flop input path of the port would capture stale data
  always @(negedge clk) begin
    rd_late <= rd_act;
  end

  assign drive = (rd_act && (!slow || rd_late)) ? mem[adr_q[4:1]] : float_q;
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & drive);
endmodule : ext_mem_model
`default_nettype wire

// *** sim/tb_bus_port_gpio_altfunc.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_bus_port_gpio_altfunc;
  import port_pkg::*;

  localparam logic [15:0] GP = ~BUS_PIN_MASK;
  logic        clk = 1'b0;
  logic        rst_b;
  reg_req_t    req;
  alt_drive_t  periph;
  logic        slow;
  logic [15:0] rdata, alt_in, b_in, b_out, b_oe, ad_in, ad_out, ad_oe;
  logic [15:0] ext_lvl, rv, exp_oe;
  int          bad_count = 0;
  int          compares  = 0;
  int          n_ale, n_rd, n_wr;

  bus_port_gpio_altfunc i_bus_port_gpio_altfunc (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .periph(periph),
    .alt_in(alt_in), .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe)
  );
  ext_mem_model i_ext_mem_model (
    .clk(clk), .slow(slow), .b_out(b_out), .b_oe(b_oe),
    .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in)
  );
  // undriven pins follow the outside level
  assign b_in = (b_oe & b_out) | (~b_oe & ext_lvl);

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe widths counted mid-cycle, away from the launching edge
  always @(negedge clk) begin
    n_ale += int'(b_oe[PIN_ALE] & b_out[PIN_ALE]);
    n_wr  += int'(b_oe[PIN_WR] & ~b_out[PIN_WR]);
    if (b_oe[PIN_RD] && !b_out[PIN_RD]) begin
      n_rd++;
      `CHK(ad_oe, 16'h0000)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    req.we    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.we <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    req.re   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.re <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_read

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    reg_read(OFS_ALT_SEL, rv);
    `CHK(rv, RST_ALT_SEL)
    reg_read(OFS_DIR, rv);
    `CHK(rv, RST_DIR)
    `CHK(b_oe, BUS_PIN_MASK)
    `CHK(b_out, 16'h8800)
    reg_read(5'h03, rv);
    `CHK(rv, 16'h0000)
    $display("test reset done");
  endtask : t_reset

  task automatic t_pins;
    reg_write(OFS_LATCH, 16'ha5a5);
    wait_cyc(4);
    `CHK(b_oe & GP, 16'h0000)
    reg_read(OFS_LATCH, rv);
    `CHK(rv & GP, ext_lvl & GP)
    reg_write(OFS_DIR, 16'h00ff);
    wait_cyc(4);
    `CHK(b_oe & GP, 16'h00ff)
    `CHK(b_out & 16'h00ff, 16'h00a5)
    reg_read(OFS_LATCH, rv);
    `CHK(rv & GP, (16'h00a5 | (ext_lvl & 16'hff00)) & GP)
    $display("test pins done");
  endtask : t_pins

  task automatic t_alt;
    // pin 3 left as a timer input
    periph.level <= 16'h0f0f;
    periph.oe    <= 16'hfff7;
    reg_write(OFS_DIR, 16'h0000);
    for (int p = 0; p < 16; p++) begin
      if (!BUS_PIN_MASK[p]) begin
        reg_write(OFS_ALT_SEL, 16'h0001 << p);
        wait_cyc(3);
        exp_oe = (16'h0001 << p) & 16'hfff7;
        `CHK(b_oe & GP, exp_oe)
        `CHK(b_out & exp_oe, 16'h0f0f & exp_oe)
      end
    end
    reg_write(OFS_ALT_SEL, 16'h63ff);
    wait_cyc(6);
    `CHK(b_oe & 16'h00ff, 16'h00f7)
    `CHK(b_oe & SYNC_SEL_MASK, SYNC_SEL_MASK)
    `CHK(alt_in[PIN_TIMER2_IO], ext_lvl[3])
    reg_read(OFS_ALT_SEL, rv);
    `CHK(rv, 16'hffff)
    reg_write(OFS_ALT_SEL, 16'h0000);
    periph.oe <= 16'h0000;
    $display("test alt done");
  endtask : t_alt

  task automatic ext_cycle(input logic [15:0] a, input logic [15:0] d, input logic [15:0] c);
    reg_write(OFS_EXT_ADR, a);
    reg_write(OFS_EXT_DAT, d);
    n_ale = 0;
    n_rd  = 0;
    n_wr  = 0;
    reg_write(OFS_EXT_CMD, c);
    rv = 16'h0001;
    repeat (40) if (rv[STA_BUSY_BIT]) reg_read(OFS_EXT_STA, rv);
    `CHK(rv[STA_BUSY_BIT], 1'b0)
    `CHK(n_ale, int'(ALE_CYC))
  endtask : ext_cycle

  task automatic t_ext;
    ext_cycle(16'h0004, 16'h1234, 16'h0001);
    `CHK(n_wr, int'(WR_CYC))
    `CHK(i_ext_mem_model.mem[2], 16'h1234)
    ext_cycle(16'h0005, 16'hab00, 16'h0003);
    `CHK(i_ext_mem_model.mem[2], 16'hab34)
    ext_cycle(16'h0004, 16'h00cd, 16'h0003);
    `CHK(i_ext_mem_model.mem[2], 16'habcd)
    // prompt then slow memory
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      ext_cycle(16'h0004, 16'h0000, 16'h0000);
      `CHK(n_rd, int'(RD_CYC))
      `CHK(n_wr, 0)
      reg_read(OFS_EXT_DAT, rv);
      `CHK(rv, 16'habcd)
    end
    $display("test external bus done");
  endtask : t_ext

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    rst_b   = 1'b0;
    req     = '0;
    periph  = '0;
    slow    = 1'b0;
    ext_lvl = 16'h3c3c;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_pins();
    t_alt();
    t_ext();
    test_done();
  end

  // all tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : tb_bus_port_gpio_altfunc
`default_nettype wire
